// ===== src/serial_mem_consts.svh
`ifndef SERIAL_MEM_CONSTS_SVH
`define SERIAL_MEM_CONSTS_SVH

// =====================================================
// Memory geometry
`define MEM_ADDR_W   9
`define MEM_DATA_W   8
`define FILL_W       17
`define FIFO_DEPTH   16
`define ADDR_FIRST   9'h000
`define ADDR_LAST    9'h1FF
`define ADDR_RESET   9'h000

// =====================================================
// Target address byte fields
`define TA_RW_BIT    0
`define TA_PAGE_BIT  1
`define TA_SEL_HI    3
`define TA_SEL_LO    2
`define TA_TYPE_HI   7
`define TA_TYPE_LO   4

// =====================================================
// Bit counting and reset values
`define LAST_BIT     3'h7
`define BIT_RESET    3'h0
`define BYTE_RESET   8'h00

`endif

// ===== src/serial_mem_pkg.sv
`include "serial_mem_consts.svh"

package serial_mem_pkg;
	typedef logic [`MEM_ADDR_W-1:0] mem_addr_t;
	typedef logic [`MEM_DATA_W-1:0] mem_byte_t;
	typedef logic [`FILL_W-1:0]     fill_word_t;
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_word,
		st_ack,
		st_tx,
		st_mack,
		st_ignore
	} bus_state_e;
endpackage

// ===== src/fill_fifo.sv
`timescale 1ns/1ps

module fill_fifo #(
	parameter int WIDTH = 17,	// Word width
	parameter int DEPTH = 16	// Word count, power of two
) (
	input  wire logic             clk,       // System clock
	input  wire logic             rstn,      // Async reset, active low
	input  wire logic             in_valid,  // Source offers a word
	output      logic             in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output      logic             out_valid, // Word available
	input  wire logic             out_ready, // Sink takes the word
	output      logic [WIDTH-1:0] out_data   // Word out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = store[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (!push && pop) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// =====================================================
	// Pointers and flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count     <= next_count;
			in_ready  <= next_count != FULL_COUNT;
			out_valid <= next_count != '0;
		end
	end
endmodule // fill_fifo

// ===== src/serial_mem_array.sv
`timescale 1ns/1ps
`include "serial_mem_consts.svh"

module serial_mem_array (
	input  wire logic                      clk,     // System clock
	input  wire logic                      rstn,    // Async reset, active low
	input  wire logic                      rd_en,   // Read strobe
	input  wire serial_mem_pkg::mem_addr_t rd_addr, // Read address
	output      serial_mem_pkg::mem_byte_t rd_data, // Read data, next cycle
	input  wire logic                      wr_en,   // Write strobe
	input  wire serial_mem_pkg::mem_addr_t wr_addr, // Write address
	input  wire serial_mem_pkg::mem_byte_t wr_data  // Write data
);
	serial_mem_pkg::mem_byte_t cells [2**`MEM_ADDR_W];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= `BYTE_RESET;
		end else if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule // serial_mem_array

// ===== src/serial_memory_read_control.sv
`timescale 1ns/1ps
`include "serial_mem_consts.svh"

// How it works
// - Reads take the low eight address bits from the internal address latch.
// - Read address is page bit of target byte joined to latch value.
// - First data bit is driven on the clock right after the address acknowledge.
// - Any number of bytes may be read; the counter steps after each byte.
// - A master acknowledge makes the next sequential byte go out.
// - No acknowledge then start ends transmission and begins a new command.
// - Stop on clock nine ends the read and releases the data line.
// - Start on clock nine abandons the read and begins a new command.
// - Without a proper end the device keeps driving further bytes.
// - Address 1FF steps to 000 on the next read cycle.
// - Write target byte then word byte loads the address latch.
// - Repeated start after the word byte aborts the write and reads on.
// - Select bits must match the pins; bit one pages, bit zero directs.
// - Every byte travels most significant bit first.
// - Latch steps after each byte, just before the acknowledge clock.
// - Any start aborts the current operation and readies a new command.

module serial_memory_read_control #(
	parameter logic [3:0] DEVICE_TYPE = 4'h5	// Device type code, value arbitrary
) (
	input  wire logic                       clk,                 // System clock, 40 MHz
	input  wire logic                       rstn,                // Async reset, active low
	input  wire logic                       scl_i,               // Bus clock pin level
	input  wire logic                       sda_i,               // Bus data pin level
	output      logic                       sda_o,               // Data pin drive value
	output      logic                       sda_oe,              // Data pin pulled low when high
	input  wire logic [1:0]                 address_select_pins, // Select pin levels
	input  wire logic                       fill_valid,          // Preload word offered
	input  wire serial_mem_pkg::mem_addr_t  fill_addr,           // Preload address
	input  wire serial_mem_pkg::mem_byte_t  fill_data,           // Preload byte
	output      logic                       fill_ready,          // Preload queue has room
	output      logic                       read_active,         // A read transfer is running
	output      serial_mem_pkg::mem_addr_t  cur_addr             // Internal address latch
);
	// =====================================================
	// Declarations
	logic                        scl_m;
	logic                        scl_s;
	logic                        scl_q;
	logic                        sda_m;
	logic                        sda_s;
	logic                        sda_q;
	logic [1:0]                  sel_m;
	logic [1:0]                  sel_s;
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_det;
	logic                        stop_det;
	serial_mem_pkg::bus_state_e  state;
	serial_mem_pkg::bus_state_e  after_ack;
	serial_mem_pkg::mem_byte_t   shift;
	logic [2:0]                  bit_cnt;
	logic                        byte_full;
	logic                        mack_ok;
	serial_mem_pkg::mem_addr_t   mem_addr;
	logic                        rd_en;
	serial_mem_pkg::mem_byte_t   rd_data;
	logic                        rx_bit;
	logic                        addr_done;
	logic                        addr_hit;
	logic                        word_done;
	logic                        ack_end;
	logic                        tx_next;
	logic                        tx_end;
	logic                        mack_sample;
	logic                        mack_go;
	logic                        drain_valid;
	logic                        drain_ready;
	serial_mem_pkg::fill_word_t  drain_word;

	function automatic serial_mem_pkg::mem_addr_t addr_next(input serial_mem_pkg::mem_addr_t a);
		addr_next = (a == `ADDR_LAST) ? `ADDR_FIRST : a + 9'h001;
	endfunction

	function automatic logic target_match(input serial_mem_pkg::mem_byte_t b, input logic [1:0] sel);
		target_match = (b[`TA_TYPE_HI:`TA_TYPE_LO] == DEVICE_TYPE) && (b[`TA_SEL_HI:`TA_SEL_LO] == sel);
	endfunction

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// =====================================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_q <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_q <= 1'b1;
			sel_m <= 2'h0;
			sel_s <= 2'h0;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_q <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_q <= sda_s;
			sel_m <= address_select_pins;
			sel_s <= sel_m;
		end
	end

	assign scl_rise  = scl_s && !scl_q;
	assign scl_fall  = !scl_s && scl_q;
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

	// =====================================================
	// Event decode
	assign rx_bit      = scl_rise && (state == serial_mem_pkg::st_addr || state == serial_mem_pkg::st_word);
	assign addr_done   = scl_fall && byte_full && state == serial_mem_pkg::st_addr;
	assign addr_hit    = addr_done && target_match(shift, sel_s);
	assign word_done   = scl_fall && byte_full && state == serial_mem_pkg::st_word;
	assign ack_end     = scl_fall && state == serial_mem_pkg::st_ack;
	assign tx_next     = scl_fall && state == serial_mem_pkg::st_tx && bit_cnt != `LAST_BIT;
	assign tx_end      = scl_fall && state == serial_mem_pkg::st_tx && bit_cnt == `LAST_BIT;
	assign mack_sample = scl_rise && state == serial_mem_pkg::st_mack;
	assign mack_go     = scl_fall && state == serial_mem_pkg::st_mack && mack_ok;

	sequence tx_last_s;
		tx_end;
	endsequence

	sequence read_hit_s;
		addr_hit && shift[`TA_RW_BIT];
	endsequence

	sequence first_bit_s;
		ack_end && after_ack == serial_mem_pkg::st_tx;
	endsequence

	// =====================================================
	// Bus state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state     <= serial_mem_pkg::st_idle;
			after_ack <= serial_mem_pkg::st_idle;
		end else if (start_det) begin
			state <= serial_mem_pkg::st_addr;
		end else if (stop_det) begin
			state <= serial_mem_pkg::st_idle;
		end else begin
			case (state)
				serial_mem_pkg::st_addr: begin
					if (addr_done) begin
						state <= addr_hit ? serial_mem_pkg::st_ack : serial_mem_pkg::st_idle;
						after_ack <= shift[`TA_RW_BIT] ? serial_mem_pkg::st_tx : serial_mem_pkg::st_word;
					end
				end
				serial_mem_pkg::st_word: begin
					if (word_done) begin
						state     <= serial_mem_pkg::st_ack;
						after_ack <= serial_mem_pkg::st_ignore;
					end
				end
				serial_mem_pkg::st_ack: begin
					if (ack_end) begin
						state <= after_ack;
					end
				end
				serial_mem_pkg::st_tx: begin
					if (tx_end) begin
						state <= serial_mem_pkg::st_mack;
					end
				end
				serial_mem_pkg::st_mack: begin
					if (mack_sample && sda_s) begin
						state <= serial_mem_pkg::st_idle;
					end else if (mack_go) begin
						state <= serial_mem_pkg::st_tx;
					end
				end
				serial_mem_pkg::st_ignore: begin
					state <= serial_mem_pkg::st_ignore;
				end
				serial_mem_pkg::st_idle: begin
					state <= serial_mem_pkg::st_idle;
				end
				default: begin
					state <= serial_mem_pkg::st_idle;
				end
			endcase
		end
	end

	start_abort_a: assert property (start_det |=> state == serial_mem_pkg::st_addr && !sda_oe)
		else $error("start did not restart command reception");
	read_abandon_a: assert property ((start_det
		&& (state == serial_mem_pkg::st_mack || state == serial_mem_pkg::st_idle))
		|=> state == serial_mem_pkg::st_addr && bit_cnt == `BIT_RESET && !byte_full)
		else $error("start in acknowledge clock did not abandon the read");
	nack_end_a: assert property ((mack_sample && sda_s && !start_det && !stop_det)
		|=> state == serial_mem_pkg::st_idle ##1 !sda_oe)
		else $error("no acknowledge did not end the read");
	select_miss_a: assert property ((addr_done && !target_match(shift, sel_s) && !start_det && !stop_det)
		|=> state == serial_mem_pkg::st_idle && !sda_oe)
		else $error("device answered a foreign target address");

	// =====================================================
	// Shift register and bit counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift     <= `BYTE_RESET;
			bit_cnt   <= `BIT_RESET;
			byte_full <= 1'b0;
		end else if (start_det || stop_det) begin
			bit_cnt   <= `BIT_RESET;
			byte_full <= 1'b0;
		end else if (rx_bit) begin
			shift   <= {shift[6:0], sda_s};
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == `LAST_BIT) begin
				byte_full <= 1'b1;
			end
		end else if (addr_done || word_done) begin
			byte_full <= 1'b0;
		end else if ((ack_end && after_ack == serial_mem_pkg::st_tx) || mack_go) begin
			shift   <= rd_data;
			bit_cnt <= `BIT_RESET;
		end else if (tx_next) begin
			shift   <= {shift[6:0], 1'b0};
			bit_cnt <= bit_cnt + 3'h1;
		end else if (tx_end) begin
			bit_cnt <= `BIT_RESET;
		end
	end

	// =====================================================
	// Data line drive
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sda_oe <= 1'b0;
		end else if (start_det || stop_det) begin
			sda_oe <= 1'b0;
		end else if (addr_hit || word_done) begin
			sda_oe <= 1'b1;
		end else if (addr_done) begin
			sda_oe <= 1'b0;
		end else if (ack_end) begin
			sda_oe <= (after_ack == serial_mem_pkg::st_tx) ? !rd_data[7] : 1'b0;
		end else if (tx_next) begin
			sda_oe <= !shift[6];
		end else if (tx_end) begin
			sda_oe <= 1'b0;
		end else if (mack_go) begin
			sda_oe <= !rd_data[7];
		end
	end

	assign sda_o = 1'b0;

	stop_release_a: assert property (stop_det |=> !sda_oe && state == serial_mem_pkg::st_idle)
		else $error("stop did not release the data line");
	first_bit_a: assert property ((first_bit_s and (!start_det && !stop_det))
		|=> state == serial_mem_pkg::st_tx && sda_oe == !$past(rd_data[7]))
		else $error("first data bit not driven after address acknowledge");
	msb_order_a: assert property ((tx_next && !start_det && !stop_det) |=> sda_oe == !$past(shift[6]))
		else $error("data bits not sent most significant first");
	ack_window_a: assert property (state == serial_mem_pkg::st_mack |-> !sda_oe)
		else $error("data line driven during master acknowledge");
	next_byte_a: assert property ((mack_go && !start_det && !stop_det)
		|=> state == serial_mem_pkg::st_tx && sda_oe == !$past(rd_data[7]))
		else $error("acknowledged byte not followed by the next one");

	// =====================================================
	// Master acknowledge capture
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mack_ok <= 1'b0;
		end else if (mack_sample) begin
			mack_ok <= !sda_s;
		end else if (tx_end) begin
			mack_ok <= 1'b0;
		end
	end

	// =====================================================
	// Address latch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_addr <= `ADDR_RESET;
		end else if (start_det || stop_det) begin
			mem_addr <= mem_addr;
		end else if (addr_hit) begin
			mem_addr <= {shift[`TA_PAGE_BIT], mem_addr[7:0]};
		end else if (word_done) begin
			mem_addr <= {mem_addr[`MEM_ADDR_W-1], shift};
		end else if (tx_end) begin
			mem_addr <= addr_next(mem_addr);
		end
	end

	assign cur_addr = mem_addr;

	addr_step_a: assert property ((tx_last_s and (!start_det && !stop_det))
		|=> rd_en && mem_addr == addr_next($past(mem_addr)))
		else $error("address latch did not step after a byte");
	addr_wrap_a: assert property ((tx_last_s and (mem_addr == `ADDR_LAST && !start_det && !stop_det))
		|=> mem_addr == `ADDR_FIRST)
		else $error("address did not wrap to zero");
	word_load_a: assert property ((word_done && !start_det && !stop_det)
		|=> mem_addr[7:0] == $past(shift) && sda_oe && state == serial_mem_pkg::st_ack)
		else $error("word address not loaded and acknowledged");
	page_sel_a: assert property ((read_hit_s and (!start_det && !stop_det))
		|=> rd_en && mem_addr == {$past(shift[`TA_PAGE_BIT]), $past(mem_addr[7:0])})
		else $error("read address not formed from page bit and latch");

	// =====================================================
	// Memory fetch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_en <= 1'b0;
		end else begin
			rd_en <= ((addr_hit && shift[`TA_RW_BIT]) || tx_end) && !start_det && !stop_det;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			read_active <= 1'b0;
		end else begin
			read_active <= state == serial_mem_pkg::st_tx || state == serial_mem_pkg::st_mack;
		end
	end

	assign drain_ready = !rd_en;

	// =====================================================
	// Preload path
	fill_fifo #(
		.WIDTH (`FILL_W),
		.DEPTH (`FIFO_DEPTH)
	) u_fill_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (fill_valid),
		.in_ready  (fill_ready),
		.in_data   ({fill_addr, fill_data}),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_word)
	);

	serial_mem_array u_mem (
		.clk     (clk),
		.rstn    (rstn),
		.rd_en   (rd_en),
		.rd_addr (mem_addr),
		.rd_data (rd_data),
		.wr_en   (drain_valid && drain_ready),
		.wr_addr (drain_word[`FILL_W-1:`MEM_DATA_W]),
		.wr_data (drain_word[`MEM_DATA_W-1:0])
	);
endmodule // serial_memory_read_control

// ===== verif/i2c_master_model.sv
`timescale 1ns/1ps

// =====================================================
// Bus master stand-in, open drain on the data wire
module i2c_master_model (
	input  wire logic clk,      // System clock
	input  wire logic sda_line, // Resolved data wire
	output      logic scl,      // Bus clock from master
	output      logic sda_low   // Master pulls data low
);
	initial begin
		scl     = 1'h1;
		sda_low = 1'h0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One link clock of 8 cycles; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		scl <= 1'h0;
		cyc(1);
		sda_low <= ~b;
		cyc(3);
		scl <= 1'h1;
		cyc(3);
		s = sda_line;
		cyc(1);
	endtask

	task automatic start_cond();
		scl <= 1'h0;
		cyc(1);
		sda_low <= 1'h0;
		cyc(3);
		scl <= 1'h1;
		cyc(2);
		sda_low <= 1'h1;
		cyc(2);
	endtask

	task automatic stop_cond();
		scl <= 1'h0;
		cyc(1);
		sda_low <= 1'h1;
		cyc(3);
		scl <= 1'h1;
		cyc(2);
		sda_low <= 1'h0;
		cyc(6);
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'h1, s);
		ack = ~s;
	endtask

	// Data line released while the device shifts out
	task automatic take_bits(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, s);
			d[i] = s;
		end
	endtask
endmodule // i2c_master_model

// ===== verif/serial_memory_read_control_tb.sv
`timescale 1ns/1ps

module serial_memory_read_control_tb;
	localparam logic [3:0] dev_type = 4'h5; // Value arbitrary

	logic                      clk;
	logic                      rstn;
	logic [1:0]                pins;
	logic                      fill_valid;
	serial_mem_pkg::mem_addr_t fill_addr;
	serial_mem_pkg::mem_byte_t fill_data;
	wire logic                 fill_ready;
	wire logic                 read_active;
	wire logic                 sda_oe;
	wire logic                 sda_out;
	wire logic                 m_scl;
	wire logic                 m_sda_low;
	wire logic                 sda_wire;
	serial_mem_pkg::mem_addr_t cur_addr;
	int                        error_cnt;
	int                        n_compared;

	assign sda_wire = ~m_sda_low & (sda_oe ? sda_out : 1'h1);

	serial_memory_read_control #(.DEVICE_TYPE(dev_type)) i_dut (
		.clk(clk), .rstn(rstn), .scl_i(m_scl), .sda_i(sda_wire), .sda_o(sda_out), .sda_oe(sda_oe),
		.address_select_pins(pins), .fill_valid(fill_valid), .fill_addr(fill_addr),
		.fill_data(fill_data), .fill_ready(fill_ready), .read_active(read_active), .cur_addr(cur_addr)
	);

	i2c_master_model i_master (.clk(clk), .sda_line(sda_wire), .scl(m_scl), .sda_low(m_sda_low));

	initial clk = 1'h0;
	always #12.5 clk = ~clk;

	// =====================================================
	// Checking and closing
	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	function automatic serial_mem_pkg::mem_byte_t pat(input serial_mem_pkg::mem_addr_t a);
		return a[7:0] ^ (a[8] ? 8'hA5 : 8'h3C);
	endfunction

	// =====================================================
	// Preload and bus sequences
	task automatic fill(input serial_mem_pkg::mem_addr_t a);
		logic r;
		int   w;
		w = 0;
		fill_valid <= 1'h1;
		fill_addr  <= a;
		fill_data  <= pat(a);
		do begin
			@(negedge clk);
			r = fill_ready;
			@(posedge clk);
			w++;
		end while (r !== 1'h1 && w < 64);
		check(9'(r), 9'h001, "preload word not taken");
	endtask

	task automatic select(input logic page, input logic [7:0] word);
		logic ack;
		i_master.start_cond();
		i_master.send_byte({dev_type, pins, page, 1'h0}, ack);
		check(9'(ack), 9'h001, "write target byte not acknowledged");
		i_master.send_byte(word, ack);
		check(9'(ack), 9'h001, "word byte not acknowledged");
	endtask

	// how: 0 nack+stop, 1 nack+start, 2 stop in 9th, 3 start in 9th
	task automatic read_run(input logic page, input int n, input serial_mem_pkg::mem_addr_t first, input int how);
		logic                      ack;
		logic                      s;
		logic [7:0]                d;
		serial_mem_pkg::mem_addr_t a;
		i_master.start_cond();
		i_master.send_byte({dev_type, pins, page, 1'h1}, ack);
		check(9'(ack), 9'h001, "read target byte not acknowledged");
		for (int k = 0; k < n; k++) begin
			a = first + 9'(k);
			i_master.take_bits(d);
			check(9'(d), 9'(pat(a)), "read byte wrong");
			check(9'(read_active), 9'h001, "read not flagged active");
			if (k < n - 1) begin
				i_master.bit_io(1'h0, s);
				check(cur_addr, a + 9'h001, "address latch not stepped");
			end
		end
		if (how < 2) begin
			i_master.bit_io(1'h1, s);
			check(9'(s), 9'h001, "data line held in acknowledge clock");
		end
		if (how == 0 || how == 2) begin
			i_master.stop_cond();
		end else begin
			i_master.start_cond();
		end
		check(cur_addr, first + 9'(n), "address latch after read");
	endtask

	// =====================================================
	// Scenarios
	task automatic sc_selective();
		select(1'h0, 8'hFE);
		read_run(1'h0, 3, 9'h0FE, 0);
		check(9'(sda_oe), 9'h000, "data line not released after stop");
	endtask

	task automatic sc_wrap();
		select(1'h1, 8'hFF);
		read_run(1'h1, 2, 9'h1FF, 1);
		read_run(1'h0, 1, 9'h001, 0);
	endtask

	task automatic sc_stop_ninth();
		read_run(1'h1, 1, 9'h102, 2);
		i_master.cyc(4);
		check(9'(sda_oe), 9'h000, "data line not released");
		check(9'(read_active), 9'h000, "read still active");
	endtask

	task automatic sc_start_ninth();
		read_run(1'h0, 1, 9'h003, 3);
		read_run(1'h0, 2, 9'h004, 0);
	endtask

	task automatic sc_refuse();
		logic ack;
		i_master.start_cond();
		i_master.send_byte({dev_type, ~pins, 1'h0, 1'h1}, ack);
		check(9'(ack), 9'h000, "wrong select pins acknowledged");
		i_master.stop_cond();
		i_master.start_cond();
		i_master.send_byte({dev_type ^ 4'h1, pins, 1'h0, 1'h1}, ack);
		check(9'(ack), 9'h000, "wrong type code acknowledged");
		i_master.stop_cond();
		check(cur_addr, 9'h006, "latch moved on refused command");
	endtask

	// =====================================================
	// Main sequence
	initial begin
		rstn       = 1'h0;
		pins       = 2'h2;
		fill_valid = 1'h0;
		fill_addr  = 9'h000;
		fill_data  = 8'h00;
		error_cnt  = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		check(cur_addr, 9'h000, "latch reset value");
		check({7'h00, sda_oe, read_active}, 9'h000, "outputs after reset");
		check(9'(fill_ready), 9'h001, "preload ready after reset");
		for (int i = 0; i < 8; i++) begin
			fill(9'h0FD + 9'(i));
			fill(9'h1FE + 9'(i));
		end
		fill_valid <= 1'h0;
		repeat (40) @(posedge clk);
		sc_selective();
		sc_wrap();
		sc_stop_ninth();
		sc_start_ninth();
		sc_refuse();
		wrap_up();
	end

	initial begin
		#500us;
		error_cnt++;
		wrap_up();
	end
endmodule // serial_memory_read_control_tb
